/* File: pldc_pkg.sv */
// Package for the presence light off-delay controller.
// Assumes an AHB-Lite register slave on a 10 MHz clock.
package pldc_pkg;
   // Clock and time base
   localparam int          CLK_HZ        = 10_000_000;
   localparam int          TICK_S        = 1;
   localparam int          TICK_CYCLES   = CLK_HZ * TICK_S;
   // Lock read-back wait in milliseconds
   localparam int          READ_WAIT_MS  = 1000;
   localparam int          READ_WAIT_CYC = (CLK_HZ / 1000) * READ_WAIT_MS;
   // Delay limits in seconds
   localparam logic [15:0] DELAY_MAX     = 16'h7fff;
   localparam logic [15:0] DELAY_DEFAULT = 16'h003c;
   // Register byte addresses
   localparam logic [7:0]  A_CFG         = 8'h00;
   localparam logic [7:0]  A_DELAY_PAR   = 8'h04;
   localparam logic [7:0]  A_LEVELS      = 8'h08;
   localparam logic [7:0]  A_EVENT       = 8'h0c;
   localparam logic [7:0]  A_SET_DELAY   = 8'h10;
   localparam logic [7:0]  A_STATUS      = 8'h14;
   localparam logic [7:0]  A_OUT         = 8'h18;
   localparam logic [7:0]  A_ACTIVE      = 8'h1c;
   // Config bit positions
   localparam int          C_SRC         = 0;
   localparam int          C_BYTE        = 1;
   localparam int          C_SETEN       = 2;
   localparam int          C_OVW         = 3;
   localparam int          C_LOCKEN      = 4;
   localparam int          C_LMODE       = 5;
   // Event register bit positions
   localparam int          E_OBJ_ON      = 0;
   localparam int          E_OBJ_OFF     = 1;
   localparam int          E_LOCK_WR     = 2;
   localparam int          E_LOCK_VAL    = 3;
   localparam int          E_BUS_RET     = 4;
   localparam int          E_DOWNLOAD    = 5;
   localparam int          E_OUT_ACK     = 6;
   // Lock state after bus return
   localparam logic [1:0]  LM_UNLOCK     = 2'h0;
   localparam logic [1:0]  LM_LOCK       = 2'h1;
   localparam logic [1:0]  LM_READ       = 2'h2;
   localparam logic [1:0]  LM_KEEP       = 2'h3;
   // Levels reset values
   localparam logic [7:0]  PCT_ON_RST    = 8'hff;
   localparam logic [7:0]  PCT_OFF_RST   = 8'h00;
   typedef enum logic [1:0] {ST_OFF, ST_ON, ST_DELAY} pldc_state_t;
endpackage : pldc_pkg

/* File: pldc_ctrl.sv */
// Presence light off-delay controller with an AHB-Lite register slave.
// Assumes one master, word transfers only, pins for the internal input.
`timescale 1ns/1ns
module pldc_ctrl
   import pldc_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES,   // Cycles per second tick
   parameter int WAIT_CYC = READ_WAIT_CYC  // Lock read answer window
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Internal input contact, asynchronous
   input  wire logic        contact_in,
   // Output telegram request
   output logic             out_req,
   output logic [7:0]       out_value,
   // Lock read request toward the bus
   output logic             lock_read_req
);
   // All state of the module
   typedef struct packed {
      logic [1:0]  sync;       // Contact synchroniser
      logic        contact;    // Previous synchronised contact
      logic [7:0]  cfg;        // Configuration
      logic [15:0] delay_par;  // Delay parameter
      logic [15:0] delay_act;  // Active delay, kept over bus failure
      logic [7:0]  pct_on;     // Byte level for on
      logic [7:0]  pct_off;    // Byte level for off
      logic        locked;     // Lock state
      logic        waiting;    // Lock read outstanding
      logic [31:0] wait_cnt;   // Lock read timeout
      logic [31:0] tick_cnt;   // Second prescaler
      logic [15:0] secs;       // Remaining delay seconds
      pldc_state_t st;         // Light state
      logic        lights;     // Last commanded light level
      logic        out_req;    // Telegram pending
      logic [7:0]  out_value;  // Telegram value
      logic        lrd_req;    // Lock read request pending
      logic        rej;        // Sticky rejected delay write
      logic        dph;        // Write data phase pending
      logic [7:0]  daddr;      // Data phase address
      logic [31:0] hrdata;     // Read data
   } pldc_regs_t;

   pldc_regs_t r;       // Current state
   pldc_regs_t next_r;  // Next state

   // Register map, one aligned word per register:
   //   00 configuration: bit 0 source (1 = contact), bit 1 byte output,
   //      bit 2 set-delay enable, bit 3 overwrite on download,
   //      bit 4 lock enable, bits 6:5 lock mode after bus return
   //   04 delay parameter in seconds, loaded on download when enabled
   //   08 byte levels: on level in bits 7:0, off level in bits 15:8
   //   0c event strobes: object on, object off, lock write with value,
   //      bus return, download and telegram acknowledge
   //   10 set-delay object, refused above the maximum
   //   14 status, bit 0 is the sticky refusal flag (write one to clear)
   //   18 pending telegram value, bit 8 the lock read request
   //   1c active delay in the low half, remaining seconds in the high half
   // Unmapped offsets read as zero and ignore writes.

   logic addr_ok;    // Accepted address phase
   logic start_ev;   // Motion start event
   logic stop_ev;    // Motion stop event
   logic [7:0] wa;   // Write address in data phase
   logic [31:0] ev;  // Event strobes written this cycle

   // Priority inside the next-state process follows source order: later
   // assignments win. The order is chosen so that
   //   - a telegram request raised in the same cycle as an acknowledge
   //     survives, since the acknowledge clears first and motion sets later
   //   - a lock read request raised by bus return survives the acknowledge
   //   - clearing the lock enable always forces the function unlocked
   //   - bus return resets the light state but never the active delay,
   //     which is how the received delay outlives a bus voltage failure
   // The event strobes live for exactly one cycle: the data phase of a
   // write to the event register. Software must not rely on two strobes
   // written in separate words being seen as one.

   // Next state logic
   always_comb begin
      next_r   = r;
      addr_ok  = hsel && hready && htrans[1];
      wa       = r.daddr;
      ev       = (r.dph && wa == A_EVENT) ? hwdata : 32'h0000_0000;
      // Synchroniser; only the second stage is read below
      next_r.sync    = {r.sync[0], contact_in};
      next_r.contact = r.sync[1];
      start_ev = 1'b0;
      stop_ev  = 1'b0;
      if (r.cfg[C_SRC]) begin
         start_ev = r.sync[1] && !r.contact;
         stop_ev  = !r.sync[1] && r.contact;
      end else begin
         start_ev = ev[E_OBJ_ON];
         stop_ev  = ev[E_OBJ_OFF];
      end
      // Telegram handshake: the bus side acks a sent request
      if (ev[E_OUT_ACK]) begin
         next_r.out_req = 1'b0;
      end
      if (ev[E_OUT_ACK]) begin
         next_r.lrd_req = 1'b0;
      end
      // Register writes take effect at the end of the data phase. Delay
      // writes above the maximum are dropped whole, never clipped, so a
      // bad value cannot shorten the delay by accident.
      // Register writes
      if (r.dph) begin
         case (wa)
            A_CFG:       next_r.cfg = hwdata[7:0];
            A_DELAY_PAR: begin
               if (hwdata[15:0] <= DELAY_MAX) begin
                  next_r.delay_par = hwdata[15:0];
               end
            end
            A_LEVELS: begin
               next_r.pct_on  = hwdata[7:0];
               next_r.pct_off = hwdata[15:8];
            end
            A_SET_DELAY: begin
               if (r.cfg[C_SETEN]) begin
                  if (hwdata[15:0] <= DELAY_MAX) begin
                     next_r.delay_act = hwdata[15:0];
                  end else begin
                     next_r.rej = 1'b1;
                  end
               end
            end
            A_STATUS: begin
               // Write one clears the rejection flag
               if (hwdata[0]) begin
                  next_r.rej = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // Lock object write or read answer
      if (ev[E_LOCK_WR] && r.cfg[C_LOCKEN]) begin
         next_r.locked  = ev[E_LOCK_VAL];
         next_r.waiting = 1'b0;
      end
      // The answer window counts down from the bus return. If a lock write
      // arrives first it ends the wait and sets the lock from its value;
      // otherwise the function falls back to unlocked. The request line
      // stays up until acknowledged, independent of the wait.
      // Lock read timeout
      if (r.waiting) begin
         if (r.wait_cnt == 32'h0000_0000) begin
            next_r.waiting = 1'b0;
            next_r.locked  = 1'b0;
         end else begin
            next_r.wait_cnt = r.wait_cnt - 32'h0000_0001;
         end
      end
      // Bus voltage return; active delay is not touched
      if (ev[E_BUS_RET]) begin
         case (r.cfg[C_LMODE +: 2])
            LM_UNLOCK: next_r.locked = 1'b0;
            LM_LOCK:   next_r.locked = r.cfg[C_LOCKEN];
            LM_READ: begin
               next_r.locked   = 1'b0;
               next_r.waiting  = r.cfg[C_LOCKEN];
               next_r.lrd_req  = r.cfg[C_LOCKEN];
               next_r.wait_cnt = 32'(WAIT_CYC);
            end
            default:   next_r.locked = r.locked;
         endcase
         next_r.st = ST_OFF;
      end
      // Application download
      if (ev[E_DOWNLOAD] && r.cfg[C_OVW]) begin
         next_r.delay_act = r.delay_par;
      end // otherwise delay_act is kept
      if (!r.cfg[C_LOCKEN]) begin
         next_r.locked = 1'b0;
      end
      // Free-running prescaler; the delay state reloads it so the first counted
      // second starts at the stop event.
      // Second prescaler
      if (r.tick_cnt == 32'h0000_0000) begin
         next_r.tick_cnt = 32'(TICK_CYC - 1);
      end else begin
         next_r.tick_cnt = r.tick_cnt - 32'h0000_0001;
      end
      // Light state machine:
      //   off   -> on     on motion start, on telegram queued at once
      //   on    -> delay  on motion stop, seconds counter loaded
      //   delay -> on     on motion start, restarting the timer later
      //   delay -> off    when the seconds counter has run out
      // A stop while already off or delaying is ignored. The prescaler is
      // reloaded on entry to the delay state so the first second is a
      // full one; the off telegram comes one cycle after the last tick.
      // While locked nothing moves and no telegram is queued, so a motion
      // event during the lock is lost rather than replayed on unlock.
      // Light control, frozen while locked
      if (!r.locked && !ev[E_BUS_RET]) begin
         case (r.st)
            ST_OFF, ST_ON, ST_DELAY: begin
               if (start_ev) begin
                  next_r.st        = ST_ON;
                  next_r.lights    = 1'b1;
                  next_r.out_req   = 1'b1;
                  next_r.out_value = r.cfg[C_BYTE] ? r.pct_on
                                                   : 8'h01;
               end else if (stop_ev && r.st == ST_ON) begin
                  next_r.st       = ST_DELAY;
                  next_r.secs     = r.delay_act;
                  next_r.tick_cnt = 32'(TICK_CYC - 1);
               end else if (r.st == ST_DELAY) begin
                  if (r.secs == 16'h0000) begin
                     next_r.st        = ST_OFF;
                     next_r.lights    = 1'b0;
                     next_r.out_req   = 1'b1;
                     next_r.out_value = r.cfg[C_BYTE] ? r.pct_off
                                                      : 8'h00;
                  end else if (r.tick_cnt == 32'h0000_0000) begin
                     next_r.secs = r.secs - 16'h0001;
                  end
               end
            end
            default: next_r.st = ST_OFF;
         endcase
      end
      // Address phase is captured here; write data is applied one cycle
      // later, in the data phase, from the captured address. Read data is
      // registered at the address phase so it stands for the whole data
      // phase without depending on the next address.
      // Bus slave: zero wait states, writes land in data phase
      next_r.dph   = addr_ok && hwrite;
      next_r.daddr = haddr[7:0];
      if (addr_ok && !hwrite) begin
         case (haddr[7:0])
            A_CFG:       next_r.hrdata = {24'h000000, r.cfg};
            A_DELAY_PAR: next_r.hrdata = {16'h0000, r.delay_par};
            A_LEVELS:    next_r.hrdata = {16'h0000, r.pct_off, r.pct_on};
            A_STATUS:    next_r.hrdata = {24'h000000, 1'b0, r.st,
                                          r.waiting, r.out_req,
                                          r.lights, r.locked, r.rej};
            A_OUT:       next_r.hrdata = {23'h000000, r.lrd_req,
                                          r.out_value};
            A_ACTIVE:    next_r.hrdata = {r.secs, r.delay_act};
            default:     next_r.hrdata = 32'h0000_0000;
         endcase
      end
   end

   // Reset loads only constants. The active delay comes up at the default
   // here; a real device would reload it from non-volatile storage, which
   // lives outside this block. Bus return is a strobe, not a reset, so
   // the active delay is kept across it.

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r           <= '0;
         r.delay_par <= DELAY_DEFAULT;
         r.delay_act <= DELAY_DEFAULT;
         r.pct_on    <= PCT_ON_RST;
         r.pct_off   <= PCT_OFF_RST;
         r.st        <= ST_OFF;
      end else begin
         r <= next_r;
      end
   end

   // The slave never stalls and never errors, so ready and response are
   // tied off. They are constants rather than flops; a constant cannot
   // glitch, so nothing is lost by not registering them.

   // Outputs straight from flip-flops, ready and response tied off
   assign hrdata        = r.hrdata;
   assign hreadyout     = 1'b1;
   assign hresp         = 1'b0;
   assign out_req       = r.out_req;
   assign out_value     = r.out_value;
   assign lock_read_req = r.lrd_req;
endmodule : pldc_ctrl

/* File: pldc_ctrl_sva.sv */
// Checker for the off-delay controller, port level only.
// Assumes one AHB-Lite master and a single clock domain.
`timescale 1ns/1ns
module pldc_ctrl_sva
   import pldc_pkg::*;
(
   // Clock, reset and one-bit signals
   input wire logic        hclk, hresetn, hsel, hwrite, hready,
   input wire logic        hreadyout, hresp, out_req, lock_read_req,
   // Bus vectors
   input wire logic [31:0] haddr, hwdata, hrdata,
   input wire logic [1:0]  htrans,
   // Telegram value
   input wire logic [7:0]  out_value
);
   wire logic tk = hsel && hready && htrans[1]; // Transfer taken
   logic ev_q, br_q, ack_q, rd_out, rd_st, rd_un; // Phase trackers
   // Remember what each address phase asked for
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {ev_q, br_q, ack_q, rd_out, rd_st, rd_un} <= '0;
      end else begin
         ev_q   <= tk && hwrite && haddr[7:0] == A_EVENT;
         br_q   <= ev_q && hwdata[E_BUS_RET];
         ack_q  <= ev_q;
         rd_out <= tk && !hwrite && haddr[7:0] == A_OUT;
         rd_st  <= tk && !hwrite && haddr[7:0] == A_STATUS;
         rd_un  <= tk && !hwrite && haddr[7:0] >= 8'h20;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_ready_high: assert property (hreadyout)
      else $error("hreadyout low");
   chk_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   chk_unmapped_zero: assert property (rd_un |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   chk_out_read: assert property (rd_out |->
      hrdata[8:0] == {$past(lock_read_req), $past(out_value)})
      else $error("out readback mismatch");
   chk_status_req: assert property (rd_st |-> hrdata[3] == $past(out_req))
      else $error("status request bit mismatch");
   chk_ack_clear: assert property ($fell(out_req) |-> ack_q)
      else $error("telegram dropped without event");
   chk_lockreq_cause: assert property ($rose(lock_read_req) |-> br_q)
      else $error("lock read without bus return");
   chk_reset_idle: assert property ($rose(hresetn) |->
      !out_req && !lock_read_req)
      else $error("outputs busy after reset");
endmodule : pldc_ctrl_sva
bind pldc_ctrl pldc_ctrl_sva pldc_ctrl_sva_i (.hclk, .hresetn, .hsel,
   .hwrite, .hready, .hreadyout, .hresp, .out_req, .lock_read_req,
   .haddr, .hwdata, .hrdata, .htrans, .out_value);

/* File: pldc_det.sv */
// Presence detector contact model.
// Assumes the contact moves free of the clock, so it lags by 37 ns.
`timescale 1ns/1ns
module pldc_det (
   // Wanted contact state
   input  wire logic close_req,
   // Dry contact, high when closed
   output logic      contact_in
);
   initial contact_in = 1'b0;
   // Lag is unrelated to the clock phase on purpose
   always @(close_req) contact_in <= #37 close_req;
endmodule : pldc_det

/* File: tb.sv */
// Self-checking bench for the off-delay controller.
// Assumes short tick and lock-wait counts set through parameters.
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin errors++; \
 $display("Error %s exp %h got %h", n, e, s); end end
module tb;
   import pldc_pkg::*;
   localparam int TK = 10; // Cycles per tick
   localparam int WT = 20; // Lock read wait
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, det = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
   logic [1:0]  htrans = 0;
   logic        hreadyout, hresp, out_req, lock_read_req, contact_in;
   logic [7:0]  out_value, lon, loff;
   int          errors = 0, compares = 0, c, d, p;
   initial forever #50 hclk = ~hclk;
   pldc_ctrl #(.TICK_CYC(TK), .WAIT_CYC(WT)) pldc_ctrl_i (.hclk, .hresetn,
      .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .contact_in,
      .out_req, .out_value, .lock_read_req);
   pldc_det pldc_det_i (.close_req(det), .contact_in);
   // One single word transfer, waits for ready in both phases
   task automatic bus(input logic [7:0] a, input logic w, input int v);
      @(posedge hclk);
      {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, 24'h0, a, w};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, v};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input int v);
      bus(a, 1'b1, v);
   endtask : wr
   // Wait for a pending telegram, count edges
   task automatic wreq();
      c = 0;
      do begin @(posedge hclk); c++; end while (out_req !== 1'b1 && c < 9000);
   endtask : wreq
   // Expect one telegram, then acknowledge it
   task automatic tel(input logic [7:0] e);
      wreq();
      `CHK("out_value", e, out_value)
      wr(A_EVENT, 32'h40);
   endtask : tel
   task automatic give_verdict();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   // Watchdog covers any hung wait
   initial begin
      repeat (30000) @(posedge hclk);
      errors++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'h1733dc39));
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      bus(A_DELAY_PAR, 0, 0); `CHK("par", 32'h3c, q)
      bus(A_LEVELS, 0, 0); `CHK("levels", 32'hff, q)
      bus(8'h40, 0, 0); `CHK("hole", 32'h0, q)
      $display("test reset done");
      d = $urandom % 4 + 1;
      wr(A_CFG, 32'h4); wr(A_SET_DELAY, d);
      bus(A_ACTIVE, 0, 0); `CHK("active", d[15:0], q[15:0])
      wr(A_SET_DELAY, 32'h8000); bus(A_STATUS, 0, 0);
      `CHK("reject", 1'b1, q[0])
      bus(A_ACTIVE, 0, 0); `CHK("kept", d[15:0], q[15:0])
      wr(A_EVENT, 1); tel(8'h01);
      `CHK("prompt", 1'b1, c <= 4)
      wr(A_EVENT, 2); repeat (d * TK / 2) @(posedge hclk);
      wr(A_EVENT, 1); wr(A_EVENT, 32'h40); wr(A_EVENT, 2); wreq();
      `CHK("delay", 1'b1, c >= d * TK - 2 && c <= d * TK + 6)
      `CHK("off", 8'h00, out_value)
      wr(A_EVENT, 32'h40);
      $display("test object done");
      p = $urandom % 100;
      wr(A_EVENT, 32'h10); bus(A_ACTIVE, 0, 0);
      `CHK("persist", d[15:0], q[15:0])
      wr(A_DELAY_PAR, p); wr(A_EVENT, 32'h20); bus(A_ACTIVE, 0, 0);
      `CHK("dl keep", d[15:0], q[15:0])
      wr(A_CFG, 32'hc); wr(A_EVENT, 32'h20); bus(A_ACTIVE, 0, 0);
      `CHK("dl load", p[15:0], q[15:0])
      {lon, loff} = 16'($urandom);
      wr(A_LEVELS, {loff, lon}); wr(A_CFG, 32'h6); wr(A_SET_DELAY, 0);
      wr(A_EVENT, 1); tel(lon);
      wr(A_EVENT, 2); tel(loff);
      wr(A_CFG, 32'h5);
      det <= 1'b1; tel(8'h01);
      det <= 1'b0; tel(8'h00);
      $display("test levels done");
      wr(A_CFG, 32'h10); wr(A_EVENT, 32'hc); wr(A_EVENT, 1);
      repeat (6) @(posedge hclk);
      `CHK("locked req", 1'b0, out_req)
      for (int m = 0; m < 4; m++) begin
         wr(A_CFG, 32'h10 | (m << 5)); wr(A_EVENT, 32'hc);
         wr(A_EVENT, 32'h10); repeat (2) @(posedge hclk);
         `CHK("read req", m == 2, lock_read_req)
         wr(A_EVENT, 32'h40);
         repeat (WT + 5) @(posedge hclk);
         bus(A_STATUS, 0, 0); `CHK("lock", m % 2 == 1, q[1])
      end
      $display("test lock done");
      give_verdict();
   end
endmodule : tb
